// ==== spdif_io_ctrl_defines.vh ====
`ifndef SPDIF_IO_CTRL_DEFINES_VH
`define SPDIF_IO_CTRL_DEFINES_VH

// register byte addresses on the slave bus
`define IN_CTRL_ADDR      8'h30
`define OUT_CTRL_ADDR     8'h50
`define STATUS_ADDR       8'h60

// reset values and writable-bit masks
`define IN_CTRL_RST       16'h0010
`define OUT_CTRL_RST      16'h0054
`define IN_CTRL_MASK      16'h0013
`define OUT_CTRL_MASK     16'h015f

// input control fields
`define RX_PON_BIT        4
`define SLICER_SEL_RANGE  1:0

// output control fields
`define TX_VALID_BIT      8
`define LR_COPY_BIT       6
`define TX_PON_BIT        4
`define ENC_DIS_BIT       3
`define TX_SRC_RANGE      2:0
`define LOOP_PIN_RANGE    1:0
`define SRC_LOOP_BIT      2

// transmit source codes
`define SRC_ADC           3'h0
`define SRC_SERIAL        3'h1
`define SRC_UNUSED        3'h2
`define SRC_MIX           3'h3

// status register fields
`define ST_NOT_EMPTY_BIT  0
`define ST_FULL_BIT       1
`define ST_PINS_RANGE     7:4
`define ST_RUN_BIT        8
`define ST_LOOP_BIT       9

// buffer occupancy
`define BUF_EMPTY         2'h0
`define BUF_ONE           2'h1
`define BUF_FULL          2'h2

`endif

// ==== pin_sync.v ====
`timescale 1ns/10ps
module pin_sync #(
  parameter WIDTH = 4
) (
  input  wire             ref_clk_i,
  input  wire             rst_i,
  input  wire [WIDTH-1:0] async_i,
  output reg  [WIDTH-1:0] sync_o
);

  reg [WIDTH-1:0] meta_q;

  // two flops; first stage feeds only the second
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_q <= {WIDTH{1'b0}};
      sync_o <= {WIDTH{1'b0}};
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule

// ==== two_entry_buf.v ====
`timescale 1ns/10ps
`include "spdif_io_ctrl_defines.vh"
module two_entry_buf #(
  parameter WIDTH = 50
) (
  input  wire             ref_clk_i,
  input  wire             rst_i,
  input  wire [WIDTH-1:0] in_data_i,
  input  wire             in_valid_i,
  output reg              in_ready_o,
  output reg  [WIDTH-1:0] out_data_o,
  output reg              out_valid_o,
  input  wire             out_ready_i
);

  reg [WIDTH-1:0] spare_q;
  reg [1:0]       cnt_q;
  reg [1:0]       cnt_d;
  wire            push;
  wire            pop;

  assign push = in_valid_i & in_ready_o;
  assign pop  = out_valid_o & out_ready_i;

  // next occupancy
  always @* begin
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + 2'h1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 2'h1;
    end
  end

  // head word drives the output, spare holds the second
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      out_data_o  <= {WIDTH{1'b0}};
      spare_q     <= {WIDTH{1'b0}};
      cnt_q       <= `BUF_EMPTY;
      in_ready_o  <= 1'b0;
      out_valid_o <= 1'b0;
    end else begin
      cnt_q       <= cnt_d;
      in_ready_o  <= (cnt_d != `BUF_FULL);
      out_valid_o <= (cnt_d != `BUF_EMPTY);
      if (push && !pop) begin
        if (cnt_q == `BUF_EMPTY) begin
          out_data_o <= in_data_i;
        end else begin
          spare_q <= in_data_i;
        end
      end else if (pop && !push) begin
        out_data_o <= spare_q;
      end else if (pop && push) begin
        if (cnt_q == `BUF_ONE) begin
          out_data_o <= in_data_i;
        end else begin
          out_data_o <= spare_q;
          spare_q    <= in_data_i;
        end
      end
    end
  end

endmodule

// ==== spdif_io_control_regs.v ====
// Behaviour
// - receiver power bit low powers the input path down, high powers it on.
// - two-bit slicer selector picks input pin 0..3 for the slicer.
// - validity control bit 0 marks transmitted audio invalid, 1 valid.
// - copy bit 1 sends left channel status on right channel too.
// - transmitter power bit low powers output path down, high powers it on.
// - encoder runs while disable bit is 0, stops while it is 1; the code also stops it while the transmitter power bit is low.
// - source code 000 ADC, 001 serial audio input, 011 interpolator mix.
// - source codes 100..111 loop raw input pin 0..3 to the output.
// - loop-through pin choice is independent of the slicer pin choice.
//
// Decided for this implementation: register access over Avalon-MM.
`timescale 1ns/10ps
`include "spdif_io_ctrl_defines.vh"
module spdif_io_control_regs #(
  parameter SAMPLE_W = 24
) (
  input  wire                ref_clk_i,
  input  wire                rst_i,
  // register slave
  input  wire [7:0]          avs_address_i,
  input  wire                avs_read_i,
  input  wire                avs_write_i,
  input  wire [31:0]         avs_writedata_i,
  input  wire [3:0]          avs_byteenable_i,
  output reg  [31:0]         avs_readdata_o,
  output reg                 avs_waitrequest_o,
  // digital input pins
  input  wire                digital_in_pin0_i,
  input  wire                digital_in_pin1_i,
  input  wire                digital_in_pin2_i,
  input  wire                digital_in_pin3_i,
  // receive path
  output reg                 receiver_power_on_o,
  output reg                 slicer_in_o,
  // adc source
  input  wire [SAMPLE_W-1:0] adc_left_i,
  input  wire [SAMPLE_W-1:0] adc_right_i,
  input  wire                adc_cs_l_i,
  input  wire                adc_cs_r_i,
  input  wire                adc_valid_i,
  output wire                adc_ready_o,
  // serial audio source
  input  wire [SAMPLE_W-1:0] ser_left_i,
  input  wire [SAMPLE_W-1:0] ser_right_i,
  input  wire                ser_cs_l_i,
  input  wire                ser_cs_r_i,
  input  wire                ser_valid_i,
  output wire                ser_ready_o,
  // interpolator mix source
  input  wire [SAMPLE_W-1:0] mix_left_i,
  input  wire [SAMPLE_W-1:0] mix_right_i,
  input  wire                mix_cs_l_i,
  input  wire                mix_cs_r_i,
  input  wire                mix_valid_i,
  output wire                mix_ready_o,
  // transmit path toward the encoder
  output reg                 transmitter_power_on_o,
  output reg                 encoder_run_o,
  output reg                 transmit_validity_flag_o,
  output wire [SAMPLE_W-1:0] tx_left_o,
  output wire [SAMPLE_W-1:0] tx_right_o,
  output wire                tx_cs_l_o,
  output wire                tx_cs_r_o,
  output wire                tx_valid_o,
  input  wire                tx_ready_i,
  output reg                 tx_loop_active_o,
  output reg                 tx_loop_o
);

  localparam WORD_W = 2 * SAMPLE_W + 2;

  reg  [15:0]         in_ctrl_q;
  reg  [15:0]         out_ctrl_q;
  reg  [31:0]         rd_mux;
  wire                acc_req;
  wire                wr_take;
  wire [3:0]          pins_sync;
  wire [1:0]          slicer_sel;
  wire [2:0]          tx_src;
  wire                loop_sel;
  wire                tx_run;
  reg  [WORD_W-1:0]   src_word;
  reg                 src_valid;
  wire [WORD_W-1:0]   buf_word;
  wire                buf_in_ready;
  wire                buf_out_valid;
  wire [SAMPLE_W-1:0] pick_left;
  wire [SAMPLE_W-1:0] pick_right;
  wire                pick_cs_l;
  wire                pick_cs_r;
  reg                 adc_ready_q;
  reg                 ser_ready_q;
  reg                 mix_ready_q;
  reg  [1:0]          occ_now;
  reg  [1:0]          occ_next;
  wire                src_ready;
  wire                src_push;
  wire                buf_pop;
  wire                out_wr;
  wire                room_next;

  // byte-lane merge of a 16-bit register, reserved bits forced low
  function [15:0] merge_be;
    input [15:0] old_val;
    input [31:0] wdata;
    input [3:0]  be;
    input [15:0] mask;
    reg   [15:0] tmp;
    begin
      tmp = old_val;
      if (be[0]) begin
        tmp[7:0] = wdata[7:0];
      end
      if (be[1]) begin
        tmp[15:8] = wdata[15:8];
      end
      merge_be = tmp & mask;
    end
  endfunction

  // register address decode
  function reg_hit;
    input [7:0] addr;
    input [7:0] want;
    begin
      reg_hit = (addr == want);
    end
  endfunction

  // transmit source code decode
  function src_match;
    input [2:0] code;
    input [2:0] want;
    begin
      src_match = (code == want);
    end
  endfunction

  // field views of the control registers
  assign slicer_sel = in_ctrl_q[`SLICER_SEL_RANGE];
  assign tx_src     = out_ctrl_q[`TX_SRC_RANGE];
  assign loop_sel   = tx_src[`SRC_LOOP_BIT];
  assign tx_run     = out_ctrl_q[`TX_PON_BIT] & ~out_ctrl_q[`ENC_DIS_BIT];

  // pins cross into the clock domain before use
  pin_sync #(
    .WIDTH (4)
  ) u_pin_sync (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .async_i   ({digital_in_pin3_i, digital_in_pin2_i,
                 digital_in_pin1_i, digital_in_pin0_i}),
    .sync_o    (pins_sync)
  );

  // bus handshake: waitrequest drops one cycle after a request
  assign acc_req = avs_read_i | avs_write_i;
  assign wr_take = avs_write_i & ~avs_waitrequest_o;

  // read data selection, unmapped reads as zero
  always @* begin
    rd_mux = 32'h0000_0000;
    case (avs_address_i)
      `IN_CTRL_ADDR: begin
        rd_mux[15:0] = in_ctrl_q & `IN_CTRL_MASK;
      end
      `OUT_CTRL_ADDR: begin
        rd_mux[15:0] = out_ctrl_q & `OUT_CTRL_MASK;
      end
      `STATUS_ADDR: begin
        rd_mux[`ST_NOT_EMPTY_BIT] = buf_out_valid;
        rd_mux[`ST_FULL_BIT]      = ~buf_in_ready;
        rd_mux[`ST_PINS_RANGE]    = pins_sync;
        rd_mux[`ST_RUN_BIT]       = tx_run;
        rd_mux[`ST_LOOP_BIT]      = loop_sel;
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  // slave answer timing
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h0000_0000;
    end else begin
      if (acc_req && avs_waitrequest_o) begin
        avs_waitrequest_o <= 1'b0;
        avs_readdata_o    <= avs_read_i ? rd_mux : 32'h0000_0000;
      end else begin
        avs_waitrequest_o <= 1'b1;
      end
    end
  end

  // control register writes, masked lanes
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      in_ctrl_q  <= `IN_CTRL_RST;
      out_ctrl_q <= `OUT_CTRL_RST;
    end else if (wr_take) begin
      if (reg_hit(avs_address_i, `IN_CTRL_ADDR)) begin
        in_ctrl_q <= merge_be(in_ctrl_q, avs_writedata_i, avs_byteenable_i,
                              `IN_CTRL_MASK);
      end
      if (reg_hit(avs_address_i, `OUT_CTRL_ADDR)) begin
        out_ctrl_q <= merge_be(out_ctrl_q, avs_writedata_i, avs_byteenable_i,
                               `OUT_CTRL_MASK);
      end
    end
  end

  // receive path: power and slicer pin choice
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      receiver_power_on_o <= 1'b0;
      slicer_in_o         <= 1'b0;
    end else begin
      receiver_power_on_o <= in_ctrl_q[`RX_PON_BIT];
      if (in_ctrl_q[`RX_PON_BIT]) begin
        slicer_in_o <= pins_sync[slicer_sel];
      end else begin
        slicer_in_o <= 1'b0;
      end
    end
  end

  // transmit path control flags
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      transmitter_power_on_o   <= 1'b0;
      encoder_run_o            <= 1'b0;
      transmit_validity_flag_o <= 1'b0;
    end else begin
      transmitter_power_on_o   <= out_ctrl_q[`TX_PON_BIT];
      encoder_run_o            <= tx_run;
      transmit_validity_flag_o <= out_ctrl_q[`TX_VALID_BIT];
    end
  end

  // loop-through of a raw pin, chosen by the low bits of the source code field
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_loop_active_o <= 1'b0;
      tx_loop_o        <= 1'b0;
    end else begin
      tx_loop_active_o <= loop_sel & out_ctrl_q[`TX_PON_BIT];
      if (loop_sel && out_ctrl_q[`TX_PON_BIT]) begin
        tx_loop_o <= pins_sync[tx_src[`LOOP_PIN_RANGE]];
      end else begin
        tx_loop_o <= 1'b0;
      end
    end
  end

  // source selection; 010 and loop codes feed nothing
  always @* begin
    src_word  = {WORD_W{1'b0}};
    src_valid = 1'b0;
    case (tx_src)
      `SRC_ADC: begin
        src_word  = {adc_left_i, adc_right_i, adc_cs_l_i, adc_cs_r_i};
        src_valid = adc_valid_i;
      end
      `SRC_SERIAL: begin
        src_word  = {ser_left_i, ser_right_i, ser_cs_l_i, ser_cs_r_i};
        src_valid = ser_valid_i;
      end
      `SRC_MIX: begin
        src_word  = {mix_left_i, mix_right_i, mix_cs_l_i, mix_cs_r_i};
        src_valid = mix_valid_i;
      end
      default: begin
        src_word  = {WORD_W{1'b0}};
        src_valid = 1'b0;
      end
    endcase
  end

  // buffer handshake terms, mirrored from its own push and pop
  assign src_ready = adc_ready_q | ser_ready_q | mix_ready_q;
  assign src_push  = src_valid & src_ready & buf_in_ready;
  assign buf_pop   = buf_out_valid & tx_ready_i & encoder_run_o;
  assign out_wr    = wr_take & reg_hit(avs_address_i, `OUT_CTRL_ADDR);

  // buffer occupancy rebuilt from its flags, then stepped
  always @* begin
    if (!buf_out_valid) begin
      occ_now = `BUF_EMPTY;
    end else if (!buf_in_ready) begin
      occ_now = `BUF_FULL;
    end else begin
      occ_now = `BUF_ONE;
    end
    occ_next = occ_now;
    if (src_push && !buf_pop) begin
      occ_next = occ_now + 2'h1;
    end else if (buf_pop && !src_push) begin
      occ_next = occ_now - 2'h1;
    end
  end

  // ready held low one cycle while the selector is rewritten
  assign room_next = (occ_next != `BUF_FULL) & ~out_wr;

  // registered source ready; only the selected source sees it
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      adc_ready_q <= 1'b0;
      ser_ready_q <= 1'b0;
      mix_ready_q <= 1'b0;
    end else begin
      adc_ready_q <= room_next & src_match(tx_src, `SRC_ADC);
      ser_ready_q <= room_next & src_match(tx_src, `SRC_SERIAL);
      mix_ready_q <= room_next & src_match(tx_src, `SRC_MIX);
    end
  end

  // source ready outputs straight from their flops
  assign adc_ready_o = adc_ready_q;
  assign ser_ready_o = ser_ready_q;
  assign mix_ready_o = mix_ready_q;

  // channel status copy applied as words enter the buffer
  assign pick_left  = src_word[WORD_W-1:SAMPLE_W+2];
  assign pick_right = src_word[SAMPLE_W+1:2];
  assign pick_cs_l  = src_word[1];
  assign pick_cs_r  = out_ctrl_q[`LR_COPY_BIT] ? src_word[1] : src_word[0];

  // two-entry buffer; encoder drains only while running
  two_entry_buf #(
    .WIDTH (WORD_W)
  ) u_tx_buf (
    .ref_clk_i   (ref_clk_i),
    .rst_i       (rst_i),
    .in_data_i   ({pick_left, pick_right, pick_cs_l, pick_cs_r}),
    .in_valid_i  (src_valid & src_ready),
    .in_ready_o  (buf_in_ready),
    .out_data_o  (buf_word),
    .out_valid_o (buf_out_valid),
    .out_ready_i (tx_ready_i & encoder_run_o)
  );

  // transmit word fields straight from the buffer head flops
  assign tx_left_o  = buf_word[WORD_W-1:SAMPLE_W+2];
  assign tx_right_o = buf_word[SAMPLE_W+1:2];
  assign tx_cs_l_o  = buf_word[1];
  assign tx_cs_r_o  = buf_word[0];
  assign tx_valid_o = buf_out_valid;

endmodule

// ==== spdif_io_control_regs_monitor.sv ====
`timescale 1ns/10ps
module spdif_io_control_regs_monitor #(
  parameter SAMPLE_W = 24
) (
  input wire                ref_clk_i,
  input wire                rst_i,
  input wire                avs_read_i,
  input wire                avs_write_i,
  input wire [31:0]         avs_readdata_o,
  input wire                avs_waitrequest_o,
  input wire                receiver_power_on_o,
  input wire                slicer_in_o,
  input wire                adc_ready_o,
  input wire                ser_ready_o,
  input wire                mix_ready_o,
  input wire                transmitter_power_on_o,
  input wire                encoder_run_o,
  input wire [SAMPLE_W-1:0] tx_left_o,
  input wire                tx_valid_o,
  input wire                tx_ready_i,
  input wire                tx_loop_active_o,
  input wire                tx_loop_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);

  // one wait cycle, then a one-cycle answer
  bus_answer_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o ##1 avs_waitrequest_o) else $error("bus answer timing wrong");
  read_upper_a: assert property (!avs_waitrequest_o |-> avs_readdata_o[31:16] == 16'h0)
    else $error("read data upper half not zero");
  rx_down_a: assert property (!receiver_power_on_o |-> !slicer_in_o)
    else $error("slicer active while receiver down");
  tx_down_a: assert property (!transmitter_power_on_o |-> !encoder_run_o)
    else $error("encoder running while transmitter down");
  tx_hold_a: assert property (tx_valid_o && !(tx_ready_i && encoder_run_o)
    |=> tx_valid_o && $stable(tx_left_o)) else $error("word lost while not taken");
  source_one_a: assert property ($onehot0({adc_ready_o, ser_ready_o, mix_ready_o}))
    else $error("more than one source ready");
  loop_idle_a: assert property (!tx_loop_active_o |-> !tx_loop_o)
    else $error("loop output active while not selected");
  loop_power_a: assert property (tx_loop_active_o |-> transmitter_power_on_o)
    else $error("loop active while transmitter down");
endmodule

bind spdif_io_control_regs spdif_io_control_regs_monitor #(.SAMPLE_W(SAMPLE_W)) mon_u (
  .ref_clk_i, .rst_i, .avs_read_i, .avs_write_i, .avs_readdata_o, .avs_waitrequest_o,
  .receiver_power_on_o, .slicer_in_o, .adc_ready_o, .ser_ready_o, .mix_ready_o,
  .transmitter_power_on_o, .encoder_run_o, .tx_left_o, .tx_valid_o, .tx_ready_i,
  .tx_loop_active_o, .tx_loop_o);

// ==== encoder_sink.sv ====
`timescale 1ns/10ps
module encoder_sink (
  input  wire        ref_clk_i,
  input  wire        rst_i,
  input  wire        stall_i,
  input  wire        tx_valid_i,
  input  wire        encoder_run_i,
  input  wire [23:0] tx_left_i,
  input  wire        tx_cs_l_i,
  input  wire        tx_cs_r_i,
  output logic       tx_ready_o
);
  logic [25:0] words [$];

  // takes a word only while the encoder runs; stall holds ready low
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_ready_o <= 1'b0;
    end else begin
      tx_ready_o <= ~stall_i;
      if (tx_valid_i && tx_ready_o && encoder_run_i) begin
        words.push_back({tx_cs_l_i, tx_cs_r_i, tx_left_i});
      end
    end
  end
endmodule

// ==== test_spdif_io_control_regs.sv ====
`timescale 1ns/10ps
module test_spdif_io_control_regs;
  logic        ref_clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [7:0]  avs_address_i = 8'h0;
  logic        avs_read_i = 1'b0;
  logic        avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0]  avs_byteenable_i = 4'hf;
  logic [3:0]  pins = 4'h0;
  logic [23:0] s_left [3] = '{default: 24'h0};
  logic [2:0]  s_csl = 3'h0;
  logic [2:0]  s_csr = 3'h0;
  logic [2:0]  s_valid = 3'h0;
  logic        stall = 1'b0;
  logic [31:0] rdata;
  wire  [2:0]  s_ready;
  wire  [31:0] avs_readdata_o;
  wire  [23:0] tx_left_o, tx_right_o;
  wire         avs_waitrequest_o, receiver_power_on_o, slicer_in_o, transmitter_power_on_o;
  wire         encoder_run_o, transmit_validity_flag_o, tx_cs_l_o, tx_cs_r_o, tx_valid_o;
  wire         tx_ready_i, tx_loop_active_o, tx_loop_o;
  int          num_errors = 0;
  int          total_checks = 0;

  always #5 ref_clk_i = ~ref_clk_i;

  spdif_io_control_regs dut_u (.ref_clk_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
    .digital_in_pin0_i(pins[0]), .digital_in_pin1_i(pins[1]), .digital_in_pin2_i(pins[2]),
    .digital_in_pin3_i(pins[3]), .receiver_power_on_o, .slicer_in_o,
    .adc_left_i(s_left[0]), .adc_right_i(~s_left[0]), .adc_cs_l_i(s_csl[0]),
    .adc_cs_r_i(s_csr[0]), .adc_valid_i(s_valid[0]), .adc_ready_o(s_ready[0]),
    .ser_left_i(s_left[1]), .ser_right_i(~s_left[1]), .ser_cs_l_i(s_csl[1]),
    .ser_cs_r_i(s_csr[1]), .ser_valid_i(s_valid[1]), .ser_ready_o(s_ready[1]),
    .mix_left_i(s_left[2]), .mix_right_i(~s_left[2]), .mix_cs_l_i(s_csl[2]),
    .mix_cs_r_i(s_csr[2]), .mix_valid_i(s_valid[2]), .mix_ready_o(s_ready[2]),
    .transmitter_power_on_o, .encoder_run_o, .transmit_validity_flag_o, .tx_left_o,
    .tx_right_o, .tx_cs_l_o, .tx_cs_r_o, .tx_valid_o, .tx_ready_i, .tx_loop_active_o,
    .tx_loop_o);

  encoder_sink sink_u (.ref_clk_i, .rst_i, .stall_i(stall), .tx_valid_i(tx_valid_o),
    .encoder_run_i(encoder_run_o), .tx_left_i(tx_left_o), .tx_cs_l_i(tx_cs_l_o),
    .tx_cs_r_i(tx_cs_r_o), .tx_ready_o(tx_ready_i));

  task automatic conclude();
    if (num_errors == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tmo(input int n);
    if (n >= 50) begin
      num_errors++;
      $display("CHECK FAILED at %0t: no answer within limit", $time);
      conclude();
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask

  // one bus transfer, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk_i);
    avs_address_i <= a;
    avs_write_i <= w;
    avs_read_i <= ~w;
    avs_writedata_i <= d;
    for (n = 0; n < 50; n++) begin
      @(posedge ref_clk_i);
      if (avs_waitrequest_o === 1'b0) break;
    end
    rdata = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    tmo(n);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rdata, exp);
  endtask

  // one word from source i, held until taken
  task automatic push(input int i, input logic [23:0] d, input logic cl, input logic cr);
    int n;
    @(posedge ref_clk_i);
    s_left[i] <= d;
    s_csl[i] <= cl;
    s_csr[i] <= cr;
    s_valid[i] <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge ref_clk_i);
      if (s_ready[i] === 1'b1) break;
    end
    s_valid[i] <= 1'b0;
    tmo(n);
  endtask

  // main sequence
  initial begin
    static int codes[3] = '{0, 1, 3};
    cyc(20);
    rst_i <= 1'b0;
    rdchk(8'h30, 32'h10);
    rdchk(8'h50, 32'h54);
    chk({28'h0, receiver_power_on_o, transmitter_power_on_o, encoder_run_o,
      transmit_validity_flag_o}, 32'he);
    rdchk(8'h40, 32'h0);
    bus(1'b1, 8'h30, 32'hffffffff);
    rdchk(8'h30, 32'h13);
    bus(1'b1, 8'h50, 32'hffffffff);
    rdchk(8'h50, 32'h15f);
    cyc(2);
    chk({30'h0, transmit_validity_flag_o, encoder_run_o}, 32'h2);
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, 8'h30, 32'h10 | k);
      bus(1'b1, 8'h50, 32'h14 | ((k + 1) % 4));
      pins <= 4'h1 << k;
      cyc(5);
      chk({29'h0, tx_loop_active_o, slicer_in_o, tx_loop_o}, 32'h6);
      pins <= 4'h1 << ((k + 1) % 4);
      cyc(5);
      chk({29'h0, tx_loop_active_o, slicer_in_o, tx_loop_o}, 32'h5);
    end
    bus(1'b1, 8'h30, 32'h3);
    bus(1'b1, 8'h50, 32'h7);
    pins <= 4'h8;
    cyc(5);
    chk({30'h0, slicer_in_o, tx_loop_active_o | tx_loop_o}, 32'h0);
    // code 010 is never programmed by software
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, 8'h50, 32'h10 | codes[i]);
      stall <= 1'b1;
      push(i, 24'ha5c0 + i[23:0], 1'b1, 1'b0);
      cyc(3);
      chk({29'h0, s_ready}, 32'h1 << i);
      chk(sink_u.words.size(), 32'h0);
      stall <= 1'b0;
      cyc(4);
      chk({6'h0, sink_u.words.pop_front()}, {6'h0, 2'b10, 24'ha5c0 + i[23:0]});
    end
    bus(1'b1, 8'h50, 32'h50);
    push(0, 24'h123456, 1'b1, 1'b0);
    cyc(4);
    chk({6'h0, sink_u.words.pop_front()}, {6'h0, 2'b11, 24'h123456});
    bus(1'b1, 8'h50, 32'h18);
    push(0, 24'h1, 1'b0, 1'b1);
    push(0, 24'h2, 1'b0, 1'b1);
    cyc(3);
    chk({29'h0, tx_valid_o, s_ready[0], encoder_run_o}, 32'h4);
    chk({8'h0, tx_right_o}, 32'h00ff_fffe);
    bus(1'b0, 8'h60, 32'h0);
    chk(rdata, 32'h83);
    chk(sink_u.words.size(), 32'h0);
    bus(1'b1, 8'h50, 32'h10);
    cyc(4);
    chk(sink_u.words.size(), 32'h2);
    chk({6'h0, sink_u.words.pop_front()}, {6'h0, 2'b01, 24'h1});
    chk({6'h0, sink_u.words.pop_front()}, {6'h0, 2'b01, 24'h2});
    conclude();
  end
endmodule
